// ### verilog/cpusf_core.sv
// Purpose: Processor flags register, bank map decode and common RAM with APB access
// Assumes: rst_i is power-on or brown-out reset; other_reset_i any other reset
// Notes:   APB answers with no wait state; read data is captured in setup
//
// Functional notes
// - Any instruction may target the flags register
// - Flag-updating ops override written zero and carries
// - Time-out and power-down bits never written
// - Bits seven to five read zero
// - Time-out set by power-up/clear/sleep, cleared by timeout
// - Power-down set by power-up/clear, cleared by sleep
// - Zero flag reflects zero result
// - Digit carry from bit three on add/sub
// - Carry from top bit on add/sub
// - Subtract carries are inverted borrows
// - Subtract adds two's complement of operand
// - Rotates load carry with shifted-out bit
// - Power-on sets cause flags; other resets keep arithmetic
// - Peripheral region at offsets 0Ch to 1Fh
// - Up to 80 bytes general RAM per bank
// - 16 bytes common RAM shared by all banks
// - 32 banks of 128 bytes, chosen by bank select
// - Core registers at first 12 offsets, every bank
`timescale 1ns/10ps
module cpusf_core
  import cpusf_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                other_reset_i,
  input  wire cpusf_exec_s         exec_i,
  input  wire logic                clear_watchdog_i,
  input  wire logic                sleep_i,
  input  wire logic                watchdog_timeout_i,
  input  wire logic [OFS_W-1:0]    addr_ofs_i,
  output logic [7:0]               result_o,
  output logic [7:0]               flags_o,
  output logic [BANK_W-1:0]        bank_o,
  output cpusf_map_s               map_o,
  input  wire logic [11:0]         paddr_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [31:0]         pwdata_i,
  input  wire logic [3:0]          pstrb_i,
  output logic                     pready_o,
  output logic [31:0]              prdata_o,
  output logic                     pslverr_o
);

  function automatic cpusf_map_s map_offset(input logic [OFS_W-1:0]  ofs,
                                            input logic [BANK_W-1:0] bank);
    cpusf_map_s m;
    m.lin_addr = {bank, ofs};
    if (ofs < CORE_END) begin
      m.region   = REG_CORE;
      m.lin_addr = {{BANK_W{1'b0}}, ofs};
    end else if (ofs <= PERIPH_LAST) begin
      m.region   = REG_PERIPH;
    end else if (ofs < COMMON_FIRST) begin
      m.region   = REG_GENRAM;
    end else begin
      // Shared storage: same linear address whatever bank is selected
      m.region   = REG_COMMON;
      m.lin_addr = {{BANK_W{1'b0}}, ofs};
    end
    return m;
  endfunction : map_offset

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] target);
    return a == target;
  endfunction : is_addr

  // Flags group
  logic [4:0]   flags_q;
  logic [4:0]   flags_d;
  logic [7:0]   result_q;
  logic [7:0]   result_d;
  cpusf_alu_s   alu;
  logic         apb_wr;
  logic         flags_wr_apb;

  cpusf_alu u_alu (
    .exec_i  (exec_i),
    .carry_i (flags_q[FLAG_C]),
    .alu_o   (alu)
  );

  assign apb_wr       = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign flags_wr_apb = apb_wr & is_addr(paddr_i, ADDR_FLAGS);

  always_comb begin
    flags_d  = flags_q;
    result_d = result_q;
    if (exec_i.valid) begin
      result_d = alu.result;
      for (int i = 0; i < 3; i++) begin
        if (alu.upd[i]) begin
          flags_d[i] = (i == FLAG_Z) ? alu.z : ((i == FLAG_DIGIT) ? alu.dc : alu.c);
        end
      end
      // Any flag update blocks the whole low-bit write
      if (exec_i.to_flags && alu.upd == 3'h0) begin
        flags_d[2:0] = alu.result[2:0];
      end
    end else if (flags_wr_apb) begin
      flags_d[2:0] = pwdata_i[2:0];
    end
    if (clear_watchdog_i) begin
      flags_d[FLAG_TIMEOUT] = 1'b1;
      flags_d[FLAG_PWRDN]   = 1'b1;
    end else if (sleep_i) begin
      flags_d[FLAG_TIMEOUT] = 1'b1;
      flags_d[FLAG_PWRDN]   = 1'b0;
    end
    // A time-out beats a simultaneous clear, so the cause is not lost
    if (watchdog_timeout_i) begin
      flags_d[FLAG_TIMEOUT] = 1'b0;
    end
    if (other_reset_i) begin
      result_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q  <= FLAGS_POR[4:0];
      result_q <= 8'h00;
    end else begin
      flags_q  <= flags_d;
      result_q <= result_d;
    end
  end

  assign flags_o  = {3'b000, flags_q};
  assign result_o = result_q;

  // Bank map group
  logic [BANK_W-1:0] bank_q;
  logic [BANK_W-1:0] bank_d;
  logic [OFS_W-1:0]  map_ofs_q;
  logic [OFS_W-1:0]  map_ofs_d;
  cpusf_map_s        map_q;
  cpusf_map_s        map_d;
  cpusf_map_s        apb_map;

  assign apb_map = map_offset(map_ofs_q, bank_q);

  always_comb begin
    bank_d    = bank_q;
    map_ofs_d = map_ofs_q;
    map_d     = map_offset(addr_ofs_i, bank_q);
    if (apb_wr && is_addr(paddr_i, ADDR_BANK)) begin
      bank_d = pwdata_i[BANK_W-1:0];
    end
    if (apb_wr && is_addr(paddr_i, ADDR_MAP_OFS)) begin
      map_ofs_d = pwdata_i[OFS_W-1:0];
    end
    // Other resets reopen bank zero but leave the flags alone
    if (other_reset_i) begin
      bank_d    = '0;
      map_ofs_d = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bank_q    <= '0;
      map_ofs_q <= '0;
      map_q     <= '0;
    end else begin
      bank_q    <= bank_d;
      map_ofs_q <= map_ofs_d;
      map_q     <= map_d;
    end
  end

  assign bank_o = bank_q;
  assign map_o  = map_q;

  // Common RAM group, flip-flop storage
  logic [7:0] common_q [COMMON_BYTES];
  logic [7:0] common_d [COMMON_BYTES];
  logic       common_sel;

  assign common_sel = (apb_map.region == REG_COMMON);

  always_comb begin
    common_d = common_q;
    if (apb_wr && is_addr(paddr_i, ADDR_COMMON) && common_sel) begin
      common_d[map_ofs_q[3:0]] = pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < COMMON_BYTES; i++) begin
        common_q[i] <= 8'h00;
      end
    end else begin
      common_q <= common_d;
    end
  end

  // APB read group: data and error captured in setup, shown in access
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        apb_setup;

  assign apb_setup = psel_i & ~penable_i;

  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (apb_setup) begin
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (is_addr(paddr_i, ADDR_FLAGS)) begin
        prdata_d[7:0] = flags_o;
      end else if (is_addr(paddr_i, ADDR_BANK)) begin
        prdata_d[BANK_W-1:0] = bank_q;
      end else if (is_addr(paddr_i, ADDR_MAP_OFS)) begin
        prdata_d[OFS_W-1:0] = map_ofs_q;
      end else if (is_addr(paddr_i, ADDR_MAP_INFO)) begin
        prdata_d[11:0] = apb_map.lin_addr;
        prdata_d[MAP_REGION_LSB+:2] = apb_map.region;
      end else if (is_addr(paddr_i, ADDR_COMMON)) begin
        // Unimplemented locations read as zero
        prdata_d[7:0] = common_sel ? common_q[map_ofs_q[3:0]] : 8'h00;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready_o  = psel_i & penable_i;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q & psel_i & penable_i;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_no_cause;
    !clear_watchdog_i && !sleep_i && !watchdog_timeout_i;
  endsequence
  sequence s_sleep;
    sleep_i && !clear_watchdog_i && !watchdog_timeout_i;
  endsequence
  sequence s_flag_write;
    (exec_i.valid && exec_i.to_flags) ##0 s_no_cause;
  endsequence

  a_upper_bits_zero: assert property (flags_o[7:5] == 3'b000)
    else $error("upper flag bits not zero");
  a_cause_bits_locked: assert property (s_flag_write |=> $stable(flags_o[4:3]))
    else $error("cause bits changed by a write");
  a_timeout_clears: assert property (watchdog_timeout_i |=> !flags_o[FLAG_TIMEOUT])
    else $error("timeout did not clear flag");
  a_sleep_marks_pd: assert property (s_sleep |=> flags_o[FLAG_TIMEOUT] && !flags_o[FLAG_PWRDN])
    else $error("sleep flags wrong");
  a_zero_tracks: assert property (exec_i.valid && alu.upd[FLAG_Z]
                                  |=> flags_o[FLAG_Z] == (result_o == 8'h00))
    else $error("zero flag mismatch");
  a_sub_no_borrow: assert property (exec_i.valid && exec_i.op == OP_SUB
                                    |=> flags_o[FLAG_C] == ($past(exec_i.a) >= $past(exec_i.b)))
    else $error("subtract borrow wrong");
  a_add_digit: assert property (exec_i.valid && exec_i.op == OP_ADD
                                |=> flags_o[FLAG_DIGIT] ==
                                    (({1'b0, $past(exec_i.a[3:0])} +
                                      {1'b0, $past(exec_i.b[3:0])}) > 5'h0f))
    else $error("digit carry wrong");
  a_rotate_carry: assert property (exec_i.valid && exec_i.op == OP_ROR
                                   |=> flags_o[FLAG_C] == $past(exec_i.a[0]))
    else $error("rotate carry wrong");
  a_plain_write: assert property (s_flag_write ##0 (alu.upd == 3'h0)
                                  |=> flags_o[2:0] == result_o[2:0])
    else $error("flag write not taken");
  a_core_any_bank: assert property (addr_ofs_i < CORE_END
                                    |=> map_o.region == REG_CORE && map_o.lin_addr[11:7] == 5'h00)
    else $error("core register banked");
  a_soft_reset_keeps: assert property (other_reset_i && !exec_i.valid && !flags_wr_apb
                                       ##0 s_no_cause |=> $stable(flags_o))
    else $error("other reset changed flags");

endmodule : cpusf_core

// ### verilog/cpusf_pkg.sv
// Purpose: Shared constants and types for the status flags and bank map block
// Assumes: 8-bit data path, 32 banks of 128 bytes
// Notes:   Register byte offsets sit on 32-bit APB words
package cpusf_pkg;

  // APB register byte offsets
  localparam logic [11:0] ADDR_FLAGS    = 12'h000;
  localparam logic [11:0] ADDR_BANK     = 12'h004;
  localparam logic [11:0] ADDR_MAP_OFS  = 12'h008;
  localparam logic [11:0] ADDR_MAP_INFO = 12'h00c;
  localparam logic [11:0] ADDR_COMMON   = 12'h010;

  // Flag bit positions in processor_flags
  localparam int unsigned FLAG_C       = 0;
  localparam int unsigned FLAG_DIGIT   = 1;
  localparam int unsigned FLAG_Z       = 2;
  localparam int unsigned FLAG_PWRDN   = 3;
  localparam int unsigned FLAG_TIMEOUT = 4;

  // Power-on and brown-out value: time-out and power-down set, arithmetic clear
  localparam logic [7:0] FLAGS_POR = 8'h18;

  // Bank layout
  localparam int unsigned BANK_COUNT   = 32;
  localparam int unsigned BANK_BYTES   = 128;
  localparam int unsigned BANK_W       = 5;
  localparam int unsigned OFS_W        = 7;
  localparam logic [6:0]  CORE_END     = 7'h0c;
  localparam logic [6:0]  PERIPH_LAST  = 7'h1f;
  localparam int unsigned GENRAM_BYTES = 80;
  localparam logic [6:0]  COMMON_FIRST = 7'h70;
  localparam int unsigned COMMON_BYTES = 16;

  // Map info field position
  localparam int unsigned MAP_REGION_LSB = 12;

  typedef enum logic [3:0] {
    OP_MOV, OP_SWAP, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR, OP_ROR, OP_ROL
  } cpusf_op_e;

  typedef enum logic [1:0] {
    REG_CORE, REG_PERIPH, REG_GENRAM, REG_COMMON
  } cpusf_region_e;

  typedef struct packed {
    logic       valid;
    cpusf_op_e  op;
    logic [7:0] a;
    logic [7:0] b;
    logic       to_flags;
  } cpusf_exec_s;

  typedef struct packed {
    logic [7:0] result;
    logic [2:0] upd;
    logic       z;
    logic       dc;
    logic       c;
  } cpusf_alu_s;

  typedef struct packed {
    cpusf_region_e region;
    logic [11:0]   lin_addr;
  } cpusf_map_s;

endpackage : cpusf_pkg

// ### verilog/cpusf_alu.sv
// Purpose: Operation result and arithmetic flag computation
// Assumes: Combinational, carry_i is the current carry flag
// Notes:   Subtraction is a minus b, done as a plus two's complement of b
`timescale 1ns/10ps
module cpusf_alu
  import cpusf_pkg::*;
(
  input  wire cpusf_exec_s exec_i,
  input  wire logic        carry_i,
  output cpusf_alu_s       alu_o
);

  function automatic logic [8:0] add_byte(input logic [7:0] x,
                                          input logic [7:0] y,
                                          input logic       cin);
    return {1'b0, x} + {1'b0, y} + {8'h00, cin};
  endfunction : add_byte

  function automatic logic add_nibble_carry(input logic [3:0] x,
                                            input logic [3:0] y,
                                            input logic       cin);
    logic [4:0] s;
    s = {1'b0, x} + {1'b0, y} + {4'h0, cin};
    return s[4];
  endfunction : add_nibble_carry

  logic [8:0] sum;

  always_comb begin
    alu_o = '0;
    alu_o.c = carry_i;
    sum = '0;
    unique case (exec_i.op)
      OP_MOV: alu_o.result = exec_i.a;
      OP_SWAP: alu_o.result = {exec_i.a[3:0], exec_i.a[7:4]};
      OP_ADD: begin
        sum          = add_byte(exec_i.a, exec_i.b, 1'b0);
        alu_o.result = sum[7:0];
        alu_o.c      = sum[8];
        alu_o.dc     = add_nibble_carry(exec_i.a[3:0], exec_i.b[3:0], 1'b0);
        alu_o.upd    = 3'h7;
      end
      OP_SUB: begin
        // Carry out of the complement add is the inverted borrow
        sum          = add_byte(exec_i.a, ~exec_i.b, 1'b1);
        alu_o.result = sum[7:0];
        alu_o.c      = sum[8];
        alu_o.dc     = add_nibble_carry(exec_i.a[3:0], ~exec_i.b[3:0], 1'b1);
        alu_o.upd    = 3'h7;
      end
      OP_AND: begin
        alu_o.result = exec_i.a & exec_i.b;
        alu_o.upd    = 3'h4;
      end
      OP_IOR: begin
        alu_o.result = exec_i.a | exec_i.b;
        alu_o.upd    = 3'h4;
      end
      OP_XOR: begin
        alu_o.result = exec_i.a ^ exec_i.b;
        alu_o.upd    = 3'h4;
      end
      OP_CLR: begin
        alu_o.result = 8'h00;
        alu_o.upd    = 3'h4;
      end
      OP_ROR: begin
        alu_o.result = {carry_i, exec_i.a[7:1]};
        alu_o.c      = exec_i.a[0];
        alu_o.upd    = 3'h1;
      end
      OP_ROL: begin
        alu_o.result = {exec_i.a[6:0], carry_i};
        alu_o.c      = exec_i.a[7];
        alu_o.upd    = 3'h1;
      end
      default: alu_o.result = exec_i.a;
    endcase
    alu_o.z = (alu_o.result == 8'h00);
  end

endmodule : cpusf_alu

// ### dv/cpusf_core_test.sv
// Purpose: Self-checking bench for the flags register and bank map block
// Assumes: APB answers when psel and penable are high; one op per exec call
// Notes:   Expected values come from a bench model, never from the design
`timescale 1ns/10ps
module cpusf_core_test;
  import cpusf_pkg::*;

  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             other_reset_i = 1'b0;
  cpusf_exec_s      exec_i = '0;
  logic             clear_watchdog_i = 1'b0;
  logic             sleep_i = 1'b0;
  logic             watchdog_timeout_i = 1'b0;
  logic [6:0]       addr_ofs_i = '0;
  logic [7:0]       result_o;
  logic [7:0]       flags_o;
  logic [4:0]       bank_o;
  cpusf_map_s       map_o;
  logic [11:0]      paddr_i = '0;
  logic             psel_i = 1'b0;
  logic             penable_i = 1'b0;
  logic             pwrite_i = 1'b0;
  logic [31:0]      pwdata_i = '0;
  logic             pready_o;
  logic [31:0]      prdata_o;
  logic             pslverr_o;
  int               num_errors = 0;
  int               comparisons = 0;
  logic [7:0]       fl;
  logic [31:0]      rd;
  logic             er;
  logic [7:0]       ta [4] = '{8'h0f, 8'hf0, 8'h00, 8'h5a};
  logic [7:0]       tb [4] = '{8'h01, 8'h10, 8'h00, 8'ha5};
  logic [6:0]       tofs [8] = '{7'h00, 7'h0b, 7'h0c, 7'h1f, 7'h20, 7'h6f, 7'h70, 7'h7f};

  cpusf_core i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .other_reset_i(other_reset_i), .exec_i(exec_i),
    .clear_watchdog_i(clear_watchdog_i), .sleep_i(sleep_i),
    .watchdog_timeout_i(watchdog_timeout_i),
    .addr_ofs_i(addr_ofs_i), .result_o(result_o), .flags_o(flags_o), .bank_o(bank_o),
    .map_o(map_o), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o)
  );

  always #50 clk_i = ~clk_i;

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    paddr_i <= a;
    pwrite_i <= wr;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      print_verdict();
    end
  endtask : apb

  // Reference model: returns {result, flags}
  function automatic logic [15:0] model(input int op, input logic [7:0] a,
                                        input logic [7:0] b, input logic [7:0] f,
                                        input logic tf);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] nf;
    nf = f;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    if (op == 3) begin
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    end
    case (op)
      0: r = a;
      1: r = {a[3:0], a[7:4]};
      2, 3: r = s[7:0];
      4: r = a & b;
      5: r = a | b;
      6: r = a ^ b;
      7: r = 8'h00;
      8: r = {f[0], a[7:1]};
      default: r = {a[6:0], f[0]};
    endcase
    if (op >= 2 && op <= 7) nf[2] = (r == 8'h00);
    if (op == 2 || op == 3) nf[1:0] = {h[4], s[8]};
    if (op == 8) nf[0] = a[0];
    if (op == 9) nf[0] = a[7];
    if (tf && op <= 1) nf[2:0] = r[2:0];
    return {r, nf};
  endfunction : model

  task automatic exec(input int op, input logic [7:0] a, input logic [7:0] b, input logic tf);
    logic [15:0] e;
    e = model(op, a, b, fl, tf);
    @(posedge clk_i);
    exec_i <= {1'b1, op[3:0], a, b, tf};
    @(posedge clk_i);
    exec_i.valid <= 1'b0;
    #1;
    fl = e[7:0];
    chk(result_o, e[15:8]);
    chk(flags_o, fl);
  endtask : exec

  task automatic ev(input logic c, input logic s, input logic w);
    @(posedge clk_i);
    clear_watchdog_i <= c;
    sleep_i <= s;
    watchdog_timeout_i <= w;
    @(posedge clk_i);
    clear_watchdog_i <= 1'b0;
    sleep_i <= 1'b0;
    watchdog_timeout_i <= 1'b0;
    #1;
    if (c) fl[4:3] = 2'b11;
    else if (s) fl[4:3] = 2'b10;
    if (w) fl[4] = 1'b0;
    chk(flags_o, fl);
  endtask : ev

  function automatic logic [31:0] emap(input logic [6:0] o, input logic [4:0] bk);
    logic [1:0] rg;
    rg = (o < 7'h0c) ? 2'd0 : (o <= 7'h1f) ? 2'd1 : (o < 7'h70) ? 2'd2 : 2'd3;
    return {18'h0, rg, ((rg == 2'd0 || rg == 2'd3) ? {5'h00, o} : {bk, o})};
  endfunction : emap

  initial begin
    #5_000_000;
    $display("[FAIL] t=%0t got %h exp %h", $time, 32'h0, 32'h1);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    fl = FLAGS_POR;
    #1;
    chk(flags_o, 32'h18);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk(rd, 32'h18);
    $display("test reset done");

    apb(1'b1, ADDR_FLAGS, 32'hff);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    fl = 8'h1f;
    chk(rd, 32'h1f);
    $display("test register write done");

    for (int op = 0; op < 10; op++) begin
      for (int j = 0; j < 4; j++) begin
        exec(op, ta[j], tb[j], j == 3);
      end
    end
    exec(3, 8'h05, 8'h03, 1'b0);
    exec(3, 8'h03, 8'h05, 1'b0);
    exec(3, 8'h10, 8'h01, 1'b0);
    exec(7, 8'h33, 8'h00, 1'b1);
    $display("test operations done");

    ev(1'b0, 1'b0, 1'b1);
    ev(1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b1);
    $display("test events done");

    apb(1'b1, ADDR_BANK, 32'h3);
    // Write lands at the edge that ends the access; look after it settles
    #1;
    chk(bank_o, 32'h3);
    foreach (tofs[k]) begin
      @(posedge clk_i);
      addr_ofs_i <= tofs[k];
      @(posedge clk_i);
      #1;
      chk(map_o, emap(tofs[k], 5'h3));
    end
    $display("test bank map done");

    apb(1'b1, ADDR_MAP_OFS, 32'h75);
    apb(1'b1, ADDR_COMMON, 32'ha5);
    apb(1'b1, ADDR_BANK, 32'h7);
    apb(1'b0, ADDR_COMMON, 32'h0);
    chk(rd, 32'ha5);
    apb(1'b0, ADDR_MAP_INFO, 32'h0);
    chk(rd, 32'h3075);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("test common ram done");

    @(posedge clk_i);
    other_reset_i <= 1'b1;
    @(posedge clk_i);
    other_reset_i <= 1'b0;
    #1;
    chk(flags_o, fl);
    chk(bank_o, 32'h0);
    chk(result_o, 32'h0);
    $display("test other reset done");
    print_verdict();
  end

endmodule : cpusf_core_test
